// ==== common/nhbcd_regs.svh ====
`ifndef NHBCD_REGS_SVH
`define NHBCD_REGS_SVH

// Command codes, always carried on the low byte of the bus.
`define NHBCD_CMD_READ_FIRST 8'h00
`define NHBCD_CMD_READ_SECOND 8'h01
`define NHBCD_CMD_READ_SPARE 8'h50
`define NHBCD_CMD_IDENT 8'h90
`define NHBCD_CMD_RESET 8'hFF
`define NHBCD_CMD_PROG_SETUP 8'h80
`define NHBCD_CMD_PROG_CONFIRM 8'h10
`define NHBCD_CMD_COPY_START 8'h8A
`define NHBCD_CMD_ERASE_SETUP 8'h60
`define NHBCD_CMD_ERASE_CONFIRM 8'hD0
`define NHBCD_CMD_STATUS 8'h70

// Address field positions within the 26-bit flash address.
`define NHBCD_ADDR_C1_LSB 0
`define NHBCD_ADDR_C2_LSB 9
`define NHBCD_ADDR_C3_LSB 17
`define NHBCD_ADDR_C4_BIT 25
`define NHBCD_ADDR_CYCLES 3'h4

// Strobe phase length in ns and the derived count of 10 ns cycles.
`define NHBCD_CLK_NS 10
`define NHBCD_PHASE_NS 30
`define NHBCD_PHASE_CYC ((`NHBCD_PHASE_NS + `NHBCD_CLK_NS - 1) / `NHBCD_CLK_NS)

`endif

// ==== common/nhbcd_pkg.sv ====
package nhbcd_pkg;
  typedef enum logic [2:0] {
    NHBCD_OP_CMD,
    NHBCD_OP_ADDR,
    NHBCD_OP_WRITE,
    NHBCD_OP_READ,
    NHBCD_OP_WAIT_READY
  } nhbcd_op_t;
endpackage : nhbcd_pkg

// ==== logic/nhbcd_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module nhbcd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Ready is registered from the next count, so it always matches the count.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      o_in_ready <= (nxt_cnt != DEPTH[AW:0]);
    end
  end
endmodule : nhbcd_fifo
`default_nettype wire

// ==== logic/nhbcd_phase_tick.sv ====
`timescale 1ns/1ps
`include "nhbcd_regs.svh"
`default_nettype none
module nhbcd_phase_tick (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_tick
);
  logic [3:0] cnt_ff;

  // Emits one pulse per strobe phase while running.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_run) begin
      cnt_ff <= 4'h0;
      o_tick <= 1'b0;
    end else if (cnt_ff == 4'(`NHBCD_PHASE_CYC - 1)) begin
      cnt_ff <= 4'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      o_tick <= 1'b0;
    end
  end
endmodule : nhbcd_phase_tick
`default_nettype wire

// ==== logic/nhbcd_host.sv ====
// Functional notes
// - Address sent as four low bytes.
// - Wide bus: upper byte low in addresses.
// - Read pointer commands decoded.
// - Identifier read returns identity bytes.
// - Reset accepted any time.
// - Program: setup, then confirm starts.
// - Copy-back: first code, then start code.
// - Erase: setup, then confirm starts.
// - Status read accepted while busy.
// - Address entry: latch levels, four strobes.
// - Write protect high only for requests that set wp release.
// - Data load: both latches low, pulse.
// - Serial read: toggle read strobe per word.
// - Command codes on low byte only.
`timescale 1ns/1ps
`include "nhbcd_regs.svh"
`default_nettype none
module nhbcd_host
  import nhbcd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [2:0] i_req_op,
  input wire logic [7:0] i_req_cmd,
  input wire logic [25:0] i_req_addr,
  input wire logic [7:0] i_req_count,
  input wire logic i_req_wp_release,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [15:0] i_wr_data,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_done,
  output logic o_cle,
  output logic o_ale,
  output logic o_chip_sel_n,
  output logic o_write_strobe_n,
  output logic o_read_strobe_n,
  output logic o_write_protect_n,
  output logic [15:0] o_bus_out,
  output logic o_bus_oe,
  input wire logic [15:0] i_bus_in,
  input wire logic i_ready_busy_n
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_NEXT,
    ST_WAIT
  } nhbcd_state_t;

  nhbcd_state_t state_ff;
  nhbcd_op_t op_ff;
  logic [7:0] cmd_ff;
  logic [25:0] addr_ff;
  logic [7:0] left_ff;
  logic [1:0] acyc_ff;
  logic wp_ff;
  logic tick;
  logic run;
  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] fifo_data;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Returns the low byte for one address cycle; the upper byte stays low.
  function automatic logic [15:0] addr_byte(input logic [25:0] a,
                                            input logic [1:0] n);
    logic [7:0] b;
    b = 8'h00;
    case (n)
      2'd0: b = a[`NHBCD_ADDR_C1_LSB +: 8];
      2'd1: b = a[`NHBCD_ADDR_C2_LSB +: 8];
      2'd2: b = a[`NHBCD_ADDR_C3_LSB +: 8];
      default: b = {7'h00, a[`NHBCD_ADDR_C4_BIT]};
    endcase
    return {8'h00, b};
  endfunction : addr_byte

  // True for codes that set up or start a program, copy-back or erase.
  function automatic logic is_modify(input logic [7:0] c);
    return (c == `NHBCD_CMD_PROG_SETUP) || (c == `NHBCD_CMD_PROG_CONFIRM) ||
           (c == `NHBCD_CMD_ERASE_SETUP) ||
           (c == `NHBCD_CMD_ERASE_CONFIRM) || (c == `NHBCD_CMD_COPY_START);
  endfunction : is_modify

  // Tells whether another strobe cycle of the same request follows.
  function automatic logic more_cycles(input nhbcd_op_t o,
                                       input logic [1:0] n,
                                       input logic [7:0] words);
    logic more;
    more = 1'b0;
    if (o == NHBCD_OP_ADDR) begin
      more = (n != 2'h3);
    end else if ((o == NHBCD_OP_WRITE) || (o == NHBCD_OP_READ)) begin
      more = (words > 8'h01);
    end
    return more;
  endfunction : more_cycles

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  assign run = (state_ff != ST_IDLE) && (state_ff != ST_WAIT);

  nhbcd_phase_tick u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(run),
    .o_tick(tick)
  );

  // Program data is staged here; writes stall until a word is waiting.
  assign fifo_pop = (state_ff == ST_NEXT) && (op_ff == NHBCD_OP_WRITE);

  nhbcd_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(i_wr_valid),
    .o_in_ready(o_wr_ready),
    .i_in_data(i_wr_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Walks one strobe cycle through setup, low and high phases, then decides
  // in the next state whether another cycle of the same request follows.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (i_req_valid) begin
            state_ff <= (nhbcd_op_t'(i_req_op) == NHBCD_OP_WAIT_READY) ?
                        ST_WAIT : ST_SETUP;
          end
        end
        ST_SETUP: begin
          // A data load may not strobe before its word is in the buffer.
          if (tick && (op_ff != NHBCD_OP_WRITE || fifo_valid)) begin
            state_ff <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            state_ff <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            state_ff <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (more_cycles(op_ff, acyc_ff, left_ff)) begin
            state_ff <= ST_SETUP;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (i_ready_busy_n) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Holds the accepted request for its whole length.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      op_ff <= NHBCD_OP_CMD;
      cmd_ff <= 8'h00;
      addr_ff <= 26'h0;
      wp_ff <= 1'b0;
    end else if ((state_ff == ST_IDLE) && i_req_valid) begin
      op_ff <= nhbcd_op_t'(i_req_op);
      cmd_ff <= i_req_cmd;
      addr_ff <= i_req_addr;
      wp_ff <= i_req_wp_release;
    end
  end

  // Selects which of the four address bytes goes out next.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      acyc_ff <= 2'h0;
    end else if (state_ff == ST_IDLE) begin
      acyc_ff <= 2'h0;
    end else if ((state_ff == ST_NEXT) && (op_ff == NHBCD_OP_ADDR) &&
                 (acyc_ff != 2'h3)) begin
      acyc_ff <= acyc_ff + 2'h1;
    end
  end

  // Counts down the data words that are still to move.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      left_ff <= 8'h00;
    end else if ((state_ff == ST_IDLE) && i_req_valid) begin
      left_ff <= i_req_count;
    end else if ((state_ff == ST_NEXT) && (op_ff != NHBCD_OP_ADDR) &&
                 more_cycles(op_ff, acyc_ff, left_ff)) begin
      left_ff <= left_ff - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive.

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_chip_sel_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_write_protect_n <= 1'b0;
      o_bus_oe <= 1'b0;
    end else begin
      o_cle <= (state_ff != ST_IDLE) && (op_ff == NHBCD_OP_CMD);
      o_ale <= (state_ff != ST_IDLE) && (op_ff == NHBCD_OP_ADDR);
      o_chip_sel_n <= (state_ff == ST_IDLE) || (state_ff == ST_WAIT);
      // Held high only for requests that ask for it; low blocks modify.
      o_write_protect_n <= (state_ff != ST_IDLE) && wp_ff &&
                           (op_ff != NHBCD_OP_CMD || is_modify(cmd_ff) ||
                            wp_ff);
      o_write_strobe_n <= !(state_ff == ST_LOW &&
                            op_ff != NHBCD_OP_READ);
      o_read_strobe_n <= !(state_ff == ST_LOW &&
                           op_ff == NHBCD_OP_READ);
      o_bus_oe <= (state_ff == ST_SETUP || state_ff == ST_LOW ||
                   state_ff == ST_HIGH) && (op_ff != NHBCD_OP_READ);
    end
  end

  // Puts the byte or word of the current cycle on the bus.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_bus_out <= 16'h0000;
    end else begin
      case (op_ff)
        NHBCD_OP_CMD: begin
          o_bus_out <= {8'h00, cmd_ff};
        end
        NHBCD_OP_ADDR: begin
          o_bus_out <= addr_byte(addr_ff, acyc_ff);
        end
        NHBCD_OP_WRITE: begin
          o_bus_out <= fifo_data;
        end
        default: begin
          o_bus_out <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Responses.

  // Data is taken at the end of the low read-strobe phase.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_valid <= (state_ff == ST_LOW) && tick &&
                    (op_ff == NHBCD_OP_READ);
      if ((state_ff == ST_LOW) && tick) begin
        o_rd_data <= i_bus_in;
      end
    end
  end

  // Ends a request and reopens the request port.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      o_done <= ((state_ff == ST_NEXT) &&
                 !more_cycles(op_ff, acyc_ff, left_ff)) ||
                ((state_ff == ST_WAIT) && i_ready_busy_n);
      o_req_ready <= (state_ff == ST_IDLE) && !i_req_valid;
    end
  end
endmodule : nhbcd_host
`default_nettype wire

// ==== verification/nhbcd_host_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module nhbcd_host_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_chip_sel_n,
  input wire logic o_write_strobe_n,
  input wire logic o_read_strobe_n,
  input wire logic o_write_protect_n,
  input wire logic [15:0] o_bus_out,
  input wire logic o_bus_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  a_latch_excl: assert property (!(o_cle && o_ale))
    else $error("both latch strobes high");
  a_upper_low: assert property ((o_cle || o_ale) && o_bus_oe
    |-> o_bus_out[15:8] == 8'h00) else $error("upper byte not low");
  a_strobe_excl: assert property (o_write_strobe_n || o_read_strobe_n)
    else $error("both strobes low");
  a_we_select: assert property (!o_write_strobe_n |->
    !o_chip_sel_n && o_bus_oe) else $error("write strobe unselected");
  a_we_width: assert property ($fell(o_write_strobe_n) |->
    !o_write_strobe_n [*3] ##1 o_write_strobe_n)
    else $error("write strobe width");
  a_read_width: assert property ($fell(o_read_strobe_n) |->
    !o_read_strobe_n [*3] ##1 o_read_strobe_n)
    else $error("read strobe width");
  a_read_float: assert property (!o_read_strobe_n |->
    !o_bus_oe && !o_chip_sel_n) else $error("bus driven in read");
  a_data_wp: assert property (!o_write_strobe_n && !o_cle && !o_ale
    |-> o_write_protect_n) else $error("data load protected");
  c_cmd: cover property (o_cle && !o_write_strobe_n);
  c_addr: cover property (o_ale && !o_write_strobe_n);
  c_read: cover property ($fell(o_read_strobe_n));
endmodule : nhbcd_host_asserts
bind nhbcd_host nhbcd_host_asserts nhbcd_host_asserts_i (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .o_cle(o_cle),
  .o_ale(o_ale),
  .o_chip_sel_n(o_chip_sel_n),
  .o_write_strobe_n(o_write_strobe_n),
  .o_read_strobe_n(o_read_strobe_n),
  .o_write_protect_n(o_write_protect_n),
  .o_bus_out(o_bus_out),
  .o_bus_oe(o_bus_oe)
);
`default_nettype wire

// ==== verification/nhbcd_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module nhbcd_flash_model #(
  parameter int BUSY_CYC = 150,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'hC3 // Arbitrary value.
) (
  input wire logic i_sys_clk,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_read_n,
  input wire logic i_wp_n,
  input wire logic [15:0] i_bus,
  output logic [15:0] o_bus,
  output logic o_pull_low
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] adr [4];
  logic [15:0] dq [$];
  int acnt = 0;
  int col = 0;
  int bsy = 0;
  int progs = 0;
  int erases = 0;
  logic half = 1'b0;
  logic spare = 1'b0;
  logic setup = 1'b0;
  initial o_bus = 16'h0000;
  assign o_pull_low = bsy != 0;
  always @(posedge i_sys_clk) if (bsy > 0) bsy <= bsy - 1;
  always @(posedge i_we_n) begin
    if (!i_cs_n && i_cle) begin
      cmd = i_bus[7:0];
      acnt = 0;
      if (cmd == 8'hFF) bsy = 0;
      else if (bsy == 0 || cmd == 8'h70) begin
        case (cmd)
          8'h00, 8'h01: begin
            half = cmd[0];
            spare = 1'b0;
            col = 0;
          end
          8'h50: spare = 1'b1;
          8'h90: col = 0;
          8'h80: begin
            setup = 1'b1;
            dq.delete();
          end
          8'h10, 8'h8A, 8'hD0: begin
            if (i_wp_n && (cmd != 8'h10 || setup)) begin
              bsy = BUSY_CYC;
              if (cmd == 8'hD0) erases++;
              else progs++;
            end
            setup = 1'b0;
          end
          default: ;
        endcase
      end
    end else if (!i_cs_n && i_ale && acnt < 4) begin
      adr[acnt] = i_bus[7:0];
      acnt++;
    end else if (!i_cs_n) dq.push_back(i_bus);
  end
  always @(negedge i_read_n) if (!i_cs_n) begin
    case (cmd)
      8'h90: o_bus = {8'h00, col == 0 ? MAKER_ID : DEV_ID};
      8'h70: o_bus = {8'h00, i_wp_n, bsy == 0, 6'h00};
      default: o_bus = 16'(col) + {6'h00, spare, half, 8'h00};
    endcase
    col++;
  end
  // A released bus shows the inverse of the last word, not a held value.
  always @(posedge i_read_n or posedge i_cs_n) o_bus = ~o_bus;
endmodule : nhbcd_flash_model
`default_nettype wire

// ==== verification/nand_host_bus_command_decode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module nand_host_bus_command_decode_tb;
  logic clk = 1'b0, rst = 1'b1, rv = 1'b0, wp = 1'b0, wv = 1'b0;
  logic [2:0] op = 3'h0;
  logic [7:0] cmd = 8'h00, cnt = 8'h01;
  logic [25:0] adr = 26'h2B5A3C7;
  logic [15:0] wd = 16'h0000, rdd, bo, db;
  logic rdy, wrr, rdv, done, cle, ale, csn, wen, ren, wpn, oe, pl;
  logic [15:0] got [$];
  int err_total = 0, samples_checked = 0;
  wire [15:0] bus = oe ? bo : db;
  always #5 clk = ~clk;
  nhbcd_host nhbcd_host_i (.i_sys_clk(clk), .i_rst(rst), .i_req_valid(rv),
    .o_req_ready(rdy), .i_req_op(op), .i_req_cmd(cmd), .i_req_addr(adr),
    .i_req_count(cnt), .i_req_wp_release(wp), .i_wr_valid(wv),
    .o_wr_ready(wrr), .i_wr_data(wd), .o_rd_valid(rdv), .o_rd_data(rdd),
    .o_done(done), .o_cle(cle), .o_ale(ale), .o_chip_sel_n(csn),
    .o_write_strobe_n(wen), .o_read_strobe_n(ren), .o_write_protect_n(wpn),
    .o_bus_out(bo), .o_bus_oe(oe), .i_bus_in(bus), .i_ready_busy_n(!pl));
  nhbcd_flash_model nhbcd_flash_model_i (.i_sys_clk(clk), .i_cle(cle),
    .i_ale(ale), .i_cs_n(csn), .i_we_n(wen), .i_read_n(ren), .i_wp_n(wpn),
    .i_bus(bus), .o_bus(db), .o_pull_low(pl));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic req(logic [2:0] o, logic [7:0] c, logic [7:0] n, logic w);
    @(negedge clk);
    op = o;
    cmd = c;
    cnt = n;
    wp = w;
    rv = 1'b1;
    while (!rdy) @(negedge clk);
    @(negedge clk);
    rv = 1'b0;
    repeat (400) begin
      if (rdv) got.push_back(rdd);
      if (done) break;
      @(negedge clk);
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("mismatch done expected 1 seen %b", done);
    end
  endtask : req
  task automatic t_ident;
    got.delete();
    req(3'h0, 8'h90, 8'h01, 1'b0);
    req(3'h3, 8'h00, 8'h02, 1'b0);
    chk("maker id", 16'h005A, got[0]);
    chk("device id", 16'h00C3, got[1]);
    $display("ident test done");
  endtask : t_ident
  task automatic t_addr;
    logic [7:0] code [3] = '{8'h00, 8'h01, 8'h50};
    logic [1:0] ex [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      req(3'h0, code[i], 8'h01, 1'b0);
      req(3'h1, 8'h00, 8'h01, 1'b0);
      chk("pointer", {14'h0, ex[i]}, {14'h0, nhbcd_flash_model_i.spare,
        nhbcd_flash_model_i.half});
    end
    chk("addr 1", {8'h00, adr[7:0]}, {8'h00, nhbcd_flash_model_i.adr[0]});
    chk("addr 2", {8'h00, adr[16:9]}, {8'h00, nhbcd_flash_model_i.adr[1]});
    chk("addr 3", {8'h00, adr[24:17]}, {8'h00, nhbcd_flash_model_i.adr[2]});
    chk("addr 4", {15'h0, adr[25]}, {8'h00, nhbcd_flash_model_i.adr[3]});
    $display("address test done");
  endtask : t_addr
  task automatic t_program;
    int n = 0;
    logic acc;
    wv = 1'b1;
    wd = 16'hA500;
    repeat (6) begin
      acc = wrr;
      @(negedge clk);
      if (acc) begin
        n++;
        wd = 16'hA500 + 16'(n);
      end
    end
    wv = 1'b0;
    chk("fifo fill", 16'h0004, 16'(n));
    req(3'h0, 8'h80, 8'h01, 1'b1);
    req(3'h1, 8'h00, 8'h01, 1'b1);
    req(3'h2, 8'h00, 8'h04, 1'b1);
    chk("early start", 16'h0000, 16'(nhbcd_flash_model_i.progs));
    req(3'h0, 8'h10, 8'h01, 1'b1);
    chk("busy pin", 16'h0001, {15'h0, pl});
    for (int k = 0; k < 4; k++)
      chk("word", 16'hA500 + 16'(k), nhbcd_flash_model_i.dq[k]);
    req(3'h4, 8'h00, 8'h01, 1'b0);
    chk("ready pin", 16'h0000, {15'h0, pl});
    chk("fifo empty", 16'h0001, {15'h0, wrr});
    $display("program test done");
  endtask : t_program
  task automatic t_erase;
    req(3'h0, 8'h60, 8'h01, 1'b0);
    req(3'h1, 8'h00, 8'h01, 1'b0);
    req(3'h0, 8'hD0, 8'h01, 1'b0);
    chk("protected", 16'h0000, 16'(nhbcd_flash_model_i.erases));
    req(3'h0, 8'h60, 8'h01, 1'b1);
    req(3'h1, 8'h00, 8'h01, 1'b1);
    req(3'h0, 8'hD0, 8'h01, 1'b1);
    chk("erase", 16'h0001, 16'(nhbcd_flash_model_i.erases));
    req(3'h0, 8'h00, 8'h01, 1'b0);
    chk("ignored", 16'h0001, {15'h0, nhbcd_flash_model_i.spare});
    got.delete();
    req(3'h0, 8'h70, 8'h01, 1'b1);
    req(3'h3, 8'h00, 8'h01, 1'b1);
    chk("status", 16'h0080, got[0]);
    req(3'h0, 8'hFF, 8'h01, 1'b0);
    chk("reset", 16'h0000, {15'h0, pl});
    $display("erase test done");
  endtask : t_erase
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_ident;
    t_addr;
    t_program;
    t_erase;
    wrap_up;
  end
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
endmodule : nand_host_bus_command_decode_tb
`default_nettype wire
